// *** test_temp_trip_event_logic.sv ***
/* Self-checking bench for the trip and alert logic.
 * Assumes one 40 MHz clock and the host model watching the alert pin. */
`timescale 1ns/10ps
module test_temp_trip_event_logic;
	import ttev_pkg::*;
	localparam logic [12:0] UP = 13'h0500;
	localparam logic [12:0] CR = 13'h0640;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sample_valid = 1'b0;
	logic [12:0] ambient_reading = 13'h0000;
	logic        cfg_wr = 1'b0;
	logic [15:0] cfg_wdata = 16'h0000;
	logic        temp_rd_start = 1'b0;
	logic        temp_rd = 1'b0;
	logic [15:0] cfg_rdata;
	logic [7:0]  temp_rd_byte;
	logic [15:0] measured_temperature;
	logic        alert_o;
	logic        alert_oe_n;
	logic        alert_line;
	logic [15:0] e;
	int          miscompares = 0;
	int          num_checks = 0;
	ttev_top u_dut (.ref_clk(ref_clk), .rst(rst), .sample_valid(sample_valid),
		.ambient_reading(ambient_reading), .window_high_limit(UP),
		.window_low_limit(13'h0140), .critical_limit(CR), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .temp_rd_start(temp_rd_start),
		.temp_rd(temp_rd), .temp_rd_byte(temp_rd_byte),
		.measured_temperature(measured_temperature), .alert_o(alert_o),
		.alert_oe_n(alert_oe_n));
	ttev_host_model u_host (.alert_o(alert_o), .alert_oe_n(alert_oe_n),
		.alert_line(alert_line));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic cyc;
		@(posedge ref_clk);
		#2;
	endtask : cyc
	task automatic chk(input logic [15:0] exp, input logic [15:0] act);
		num_checks++;
		if (act !== exp) begin
			miscompares++;
			$display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask : chk
	task automatic wr(input logic [15:0] d);
		cfg_wdata = d;
		cfg_wr = 1'b1;
		cyc;
		cfg_wr = 1'b0;
		cyc;
	endtask : wr
	task automatic smp(input logic [12:0] t);
		ambient_reading = t;
		sample_valid = 1'b1;
		cyc;
		sample_valid = 1'b0;
		cyc;
	endtask : smp
	task automatic st(input logic [12:0] t, input logic [2:0] f);
		smp(t);
		chk({f, t[12:2], 2'h0}, measured_temperature);
	endtask : st
	task automatic line(input logic b, input bit stay);
		int n;
		n = 0;
		if (stay) begin
			repeat (4) cyc;
		end else begin
			while (alert_line !== b && n < 8) begin
				cyc;
				n++;
			end
		end
		if (!stay && alert_line !== b) begin
			miscompares++;
			results;
		end
		chk({15'h0000, b}, {15'h0000, alert_line});
	endtask : line
	task automatic t_hys;
		logic [12:0] h;
		for (int c = 0; c < 4; c++) begin
			h = (c == 0) ? 13'h0000 : 13'(12 << c);
			wr({5'h00, 2'(c), 9'h000});
			st(13'h0510, 3'h2);
			st(UP - h + 13'h0004, 3'h2);
			st(UP - h, 3'h0);
		end
	endtask : t_hys
	task automatic t_comp;
		wr(16'h0408);
		line(1'b1, 1'b0);
		st(13'h0510, 3'h2);
		line(1'b0, 1'b0);
		st(13'h04D4, 3'h2);
		st(13'h04D0, 3'h0);
		line(1'b1, 1'b0);
		st(13'h0110, 3'h0);
		st(13'h010C, 3'h1);
		line(1'b0, 1'b0);
		st(13'h0140, 3'h0);
		st(CR, 3'h6);
		st(13'h063C, 3'h2);
		st(13'h0300, 3'h0);
	endtask : t_comp
	// The latch may hold a stale event from comparator runs, so it is cleared first.
	task automatic t_int;
		wr(16'h0409);
		wr(16'h0429);
		line(1'b1, 1'b0);
		st(13'h0510, 3'h2);
		line(1'b0, 1'b0);
		wr(16'h0429);
		line(1'b1, 1'b0);
		st(CR, 3'h6);
		line(1'b0, 1'b0);
		wr(16'h0429);
		line(1'b0, 1'b1);
		st(13'h0610, 3'h2);
		line(1'b0, 1'b1);
		st(13'h060C, 3'h2);
		line(1'b1, 1'b0);
		st(13'h0300, 3'h0);
	endtask : t_int
	task automatic t_pol;
		wr(16'h000A);
		line(1'b0, 1'b0);
		st(13'h0510, 3'h2);
		chk(16'h001A, cfg_rdata);
		line(1'b1, 1'b0);
		wr(16'h002A);
		line(1'b1, 1'b1);
		st(13'h0300, 3'h0);
		line(1'b0, 1'b0);
	endtask : t_pol
	task automatic t_sd;
		wr(16'h0008);
		st(13'h0510, 3'h2);
		wr(16'h0108);
		smp(13'h0300);
		chk({3'h2, 11'h144, 2'h0}, measured_temperature);
		line(1'b0, 1'b1);
		wr(16'h0008);
		st(13'h0300, 3'h0);
	endtask : t_sd
	// Critical-only narrows the event to the critical flag; window trips stay silent.
	task automatic t_crit;
		wr(16'h040C);
		st(13'h0510, 3'h2);
		line(1'b1, 1'b1);
		st(CR, 3'h6);
		line(1'b0, 1'b0);
		st(13'h0300, 3'h0);
		line(1'b1, 1'b0);
	endtask : t_crit
	task automatic t_read;
		st(13'h1E77, 3'h1);
		e = {3'h1, 11'h79D, 2'h0};
		temp_rd_start = 1'b1;
		cyc;
		temp_rd_start = 1'b0;
		temp_rd = 1'b1;
		cyc;
		chk({8'h00, e[15:8]}, {8'h00, temp_rd_byte});
		cyc;
		temp_rd = 1'b0;
		chk({8'h00, e[7:0]}, {8'h00, temp_rd_byte});
	endtask : t_read
	task automatic results;
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	initial begin
		repeat (4) @(posedge ref_clk);
		#2;
		rst = 1'b0;
		cyc;
		chk(16'h0000, measured_temperature);
		chk(16'h0000, cfg_rdata);
		t_hys;
		t_comp;
		t_int;
		t_pol;
		t_sd;
		t_crit;
		t_read;
		wr(16'h0640);
		wr(16'h0000);
		chk(16'h0640, cfg_rdata);
		results;
	end
endmodule : test_temp_trip_event_logic

// *** ttev_alert_pin.sv ***
/*
 * Open-drain alert pin driver with programmable active level.
 * Assumes an external pull-up; the pin is only ever pulled low or released.
 */
`timescale 1ns/10ps
module ttev_alert_pin (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic asserted,
	input  wire logic active_high,
	output logic      alert_o,
	output logic      alert_oe_n
);
	import ttev_pkg::*;

	logic pull_low_r;

	// An asserted active-high pin is released; an inactive one is pulled low.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pull_low_r <= 1'b0;
		end else begin
			pull_low_r <= asserted ^ active_high; // [RL2]
		end
	end

	assign alert_o    = 1'b0;
	assign alert_oe_n = ~pull_low_r;

endmodule : ttev_alert_pin

// *** ttev_host_model.sv ***
/* Host-side view of the open-drain alert line.
 * Assumes a pull-up on the line and no other device sharing it. */
`timescale 1ns/10ps
module ttev_host_model (
	input  logic alert_o,
	input  logic alert_oe_n,
	output logic alert_line
);
	// A released line is pulled up, so it never shows the last driven level.
	assign alert_line = alert_oe_n ? 1'b1 : alert_o;
endmodule : ttev_host_model

// *** ttev_pkg.sv ***
/*
 * Constants and types shared by the temperature trip and alert logic.
 * Assumes temperatures are 13-bit two's complement counts of 0.0625 degC.
 */
package ttev_pkg;

	localparam int TTEV_TEMP_W = 13;
	localparam int TTEV_DIFF_W = 15;

	// Configuration word bit positions.
	localparam int TTEV_CFG_MODE      = 0;
	localparam int TTEV_CFG_POL       = 1;
	localparam int TTEV_CFG_CRIT_ONLY = 2;
	localparam int TTEV_CFG_OUT_EN    = 3;
	localparam int TTEV_CFG_STATUS    = 4;
	localparam int TTEV_CFG_CLEAR     = 5;
	localparam int TTEV_CFG_WIN_LOCK  = 6;
	localparam int TTEV_CFG_CRIT_LOCK = 7;
	localparam int TTEV_CFG_SHUTDOWN  = 8;
	localparam int TTEV_CFG_HYS_LO    = 9;
	localparam int TTEV_CFG_HYS_HI    = 10;

	localparam logic [15:0] TTEV_CFG_RESET = 16'h0000;

	// Measured temperature word layout.
	localparam int TTEV_WORD_CRIT  = 15;
	localparam int TTEV_WORD_ABOVE = 14;
	localparam int TTEV_WORD_BELOW = 13;
	localparam int TTEV_WORD_SIGN  = 12;
	localparam int TTEV_WORD_UNRES = 2;
	localparam logic [15:0] TTEV_WORD_RESET = 16'h0000;

	// Hysteresis codes and their size in 0.0625 degC counts.
	localparam logic [1:0] TTEV_HYS_OFF  = 2'h0;
	localparam logic [1:0] TTEV_HYS_1P5  = 2'h1;
	localparam logic [1:0] TTEV_HYS_3P0  = 2'h2;
	localparam logic [1:0] TTEV_HYS_6P0  = 2'h3;
	localparam logic [7:0] TTEV_HYS_CNT_1P5 = 8'h18;
	localparam logic [7:0] TTEV_HYS_CNT_3P0 = 8'h30;
	localparam logic [7:0] TTEV_HYS_CNT_6P0 = 8'h60;

	typedef enum logic [1:0] {
		TTEV_BYTE_IDLE,
		TTEV_BYTE_LOW
	} ttev_rd_e;

endpackage : ttev_pkg

// *** ttev_top.sv ***
/*
 * Trip flags, measured temperature word and alert output of a module
 * temperature sensor. Assumes samples, limits and register strobes come
 * from logic on ref_clk; the two-wire bus slave lives outside.
 */
// Operation
// RL1 - Alert drives only with output enable bit 3; bit 0 picks comparator/interrupt. With polarity bit 1 set, the disabled pin is still pulled low.
// RL2 - Alert active level follows polarity bit 1.
// RL3 - Above-window flag bit 14 sets when temperature exceeds upper limit.
// RL4 - Above flag clears only at or below upper limit minus hysteresis.
// RL5 - Below flag bit 13 clears at/above lower limit, sets below lower minus hysteresis.
// RL6 - Shutdown freezes alert output and trip state.
// RL7 - Interrupt mode: critical alert holds until below critical minus hysteresis.
// RL8 - Within critical hysteresis band alert acts as comparator, mode ignored.
// RL9 - Hysteresis writes ignored while either lock bit 6 or 7 is set.
// RL10 - Temperature word is 16-bit read-only, upper byte read first.
// RL11 - Two's complement 0.0625 degC counts; two lowest bits read zero.
// RL12 - Sign at bit 12, top magnitude weight 128 degC.
// RL13 - Trip flags depend only on limit comparisons, not alert settings.
// RL14 - Critical flag bit 15 is one at or above critical limit.
// RL15 - Host writes clear bit 5 to drop interrupt until next trigger.
// RL16 - Comparator mode alert is untouched by register accesses.
// RL17 - Hysteresis code 00 off, 01 1.5, 10 3, 11 6 degC.
// RL18 - Output enable is cleared at reset, alert inactive.
// RL19 - Comparator mode asserts alert while any trip flag is set; with critical-only bit 2 set, only the critical flag asserts it.
`timescale 1ns/10ps
module ttev_top #(
	parameter int TEMP_W = 13
) (
	input  wire logic                            ref_clk,
	input  wire logic                            rst,
	input  wire logic                            sample_valid,
	input  wire logic [ttev_pkg::TTEV_TEMP_W-1:0] ambient_reading,
	input  wire logic [ttev_pkg::TTEV_TEMP_W-1:0] window_high_limit,
	input  wire logic [ttev_pkg::TTEV_TEMP_W-1:0] window_low_limit,
	input  wire logic [ttev_pkg::TTEV_TEMP_W-1:0] critical_limit,
	input  wire logic                            cfg_wr,
	input  wire logic [15:0]                     cfg_wdata,
	output logic      [15:0]                     cfg_rdata,
	input  wire logic                            temp_rd_start,
	input  wire logic                            temp_rd,
	output logic      [7:0]                      temp_rd_byte,
	output logic      [15:0]                     measured_temperature,
	output logic                                 alert_o,
	output logic                                 alert_oe_n
);
	import ttev_pkg::*;

	logic [15:0] cfg_r;
	logic [15:0] word_r;
	logic        above_r;
	logic        below_r;
	logic        crit_r;
	logic        crit_hold_r;
	logic        int_r;
	logic        trig_prev_r;
	logic        alert_r;
	logic [7:0]  low_byte_r;
	logic [7:0]  rd_byte_r;
	ttev_rd_e    rd_state_r;

	logic        locked;
	logic        run;
	logic        clear_req;
	logic        above_nxt;
	logic        below_nxt;
	logic        crit_nxt;
	logic        crit_hold_nxt;
	logic        trigger;
	logic        alert_nxt;
	logic signed [TTEV_DIFF_W-1:0] t_s;
	logic signed [TTEV_DIFF_W-1:0] hi_s;
	logic signed [TTEV_DIFF_W-1:0] lo_s;
	logic signed [TTEV_DIFF_W-1:0] cr_s;
	logic signed [TTEV_DIFF_W-1:0] hys_s;
	logic [TTEV_TEMP_W-1:0] t_res;

	function automatic logic signed [TTEV_DIFF_W-1:0] sext(
		input logic [TTEV_TEMP_W-1:0] v
	);
		sext = TTEV_DIFF_W'(signed'(v));
	endfunction : sext

	function automatic logic [7:0] hys_counts(input logic [1:0] code);
		case (code)
			TTEV_HYS_1P5: hys_counts = TTEV_HYS_CNT_1P5;
			TTEV_HYS_3P0: hys_counts = TTEV_HYS_CNT_3P0;
			TTEV_HYS_6P0: hys_counts = TTEV_HYS_CNT_6P0;
			default:      hys_counts = 8'h00;
		endcase // [RL17]
	endfunction : hys_counts

	assign locked    = cfg_r[TTEV_CFG_WIN_LOCK] | cfg_r[TTEV_CFG_CRIT_LOCK];
	assign run       = ~cfg_r[TTEV_CFG_SHUTDOWN];
	assign clear_req = cfg_wr & cfg_wdata[TTEV_CFG_CLEAR];

	// Unresolved fraction bits are dropped so compares see what is reported.
	assign t_res = {ambient_reading[TTEV_TEMP_W-1:TTEV_WORD_UNRES], {TTEV_WORD_UNRES{1'b0}}}; // [RL11]
	assign t_s   = sext(t_res); // [RL12]
	assign hi_s  = sext(window_high_limit);
	assign lo_s  = sext(window_low_limit);
	assign cr_s  = sext(critical_limit);
	assign hys_s = TTEV_DIFF_W'(hys_counts(cfg_r[TTEV_CFG_HYS_HI:TTEV_CFG_HYS_LO]));

	// Flags look only at limits, never at alert configuration.
	always_comb begin
		above_nxt = above_r;
		if (t_s > hi_s) begin
			above_nxt = 1'b1; // [RL3]
		end else if (t_s <= hi_s - hys_s) begin
			above_nxt = 1'b0; // [RL4]
		end
		below_nxt = below_r;
		if (t_s < lo_s - hys_s) begin
			below_nxt = 1'b1; // [RL5]
		end else if (t_s >= lo_s) begin
			below_nxt = 1'b0; // [RL5]
		end
		crit_nxt = (t_s >= cr_s); // [RL14] [RL13]
		crit_hold_nxt = crit_hold_r;
		if (t_s >= cr_s) begin
			crit_hold_nxt = 1'b1; // [RL7]
		end else if (t_s < cr_s - hys_s) begin
			crit_hold_nxt = 1'b0; // [RL7]
		end
	end

	// Configuration register with lock protection.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_r <= TTEV_CFG_RESET; // [RL18]
		end else if (cfg_wr) begin
			if (!locked) begin
				cfg_r[TTEV_CFG_MODE]   <= cfg_wdata[TTEV_CFG_MODE]; // [RL1]
				cfg_r[TTEV_CFG_POL]    <= cfg_wdata[TTEV_CFG_POL]; // [RL2]
				cfg_r[TTEV_CFG_OUT_EN] <= cfg_wdata[TTEV_CFG_OUT_EN]; // [RL1]
				cfg_r[TTEV_CFG_HYS_HI:TTEV_CFG_HYS_LO] <=
					cfg_wdata[TTEV_CFG_HYS_HI:TTEV_CFG_HYS_LO]; // [RL9]
				cfg_r[TTEV_CFG_SHUTDOWN] <= cfg_wdata[TTEV_CFG_SHUTDOWN];
			end else if (!cfg_wdata[TTEV_CFG_SHUTDOWN]) begin
				cfg_r[TTEV_CFG_SHUTDOWN] <= 1'b0;
			end
			if (!cfg_r[TTEV_CFG_WIN_LOCK]) begin
				cfg_r[TTEV_CFG_CRIT_ONLY] <= cfg_wdata[TTEV_CFG_CRIT_ONLY];
			end
			// Locks are set-only; only reset releases them.
			if (cfg_wdata[TTEV_CFG_WIN_LOCK]) begin
				cfg_r[TTEV_CFG_WIN_LOCK] <= 1'b1;
			end
			if (cfg_wdata[TTEV_CFG_CRIT_LOCK]) begin
				cfg_r[TTEV_CFG_CRIT_LOCK] <= 1'b1;
			end
		end
	end

	// Trip state advances on samples only while running.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			above_r     <= 1'b0;
			below_r     <= 1'b0;
			crit_r      <= 1'b0;
			crit_hold_r <= 1'b0;
			word_r      <= TTEV_WORD_RESET;
		end else if (sample_valid && run) begin // [RL6]
			above_r     <= above_nxt;
			below_r     <= below_nxt;
			crit_r      <= crit_nxt;
			crit_hold_r <= crit_hold_nxt;
			word_r      <= {crit_nxt, above_nxt, below_nxt, t_res}; // [RL10] [RL11]
		end
	end

	// Event condition: critical-only narrows the trigger to the critical flag.
	assign trigger = cfg_r[TTEV_CFG_CRIT_ONLY] ? crit_r : (above_r | below_r | crit_r);

	// Interrupt latch fires on a new trigger; a trigger beats a same-cycle clear.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_r       <= 1'b0;
			trig_prev_r <= 1'b0;
		end else if (run) begin // [RL6]
			trig_prev_r <= trigger;
			if (trigger && !trig_prev_r) begin
				int_r <= 1'b1;
			end else if (clear_req && cfg_r[TTEV_CFG_MODE]) begin
				int_r <= 1'b0; // [RL15]
			end
		end
	end

	always_comb begin
		if (!cfg_r[TTEV_CFG_MODE]) begin
			alert_nxt = trigger; // [RL19] [RL16]
		end else if (crit_hold_r) begin
			alert_nxt = 1'b1; // [RL8] [RL7]
		end else begin
			alert_nxt = int_r; // [RL1]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alert_r <= 1'b0;
		end else if (run) begin // [RL6]
			alert_r <= alert_nxt;
		end
	end

	ttev_alert_pin u_pin (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.asserted    (alert_r & cfg_r[TTEV_CFG_OUT_EN]), // [RL1]
		.active_high (cfg_r[TTEV_CFG_POL]),
		.alert_o     (alert_o),
		.alert_oe_n  (alert_oe_n)
	);

	// Byte reader: the low byte is captured with the high one so a word is coherent.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_state_r <= TTEV_BYTE_IDLE;
			rd_byte_r  <= 8'h00;
			low_byte_r <= 8'h00;
		end else if (temp_rd_start) begin
			rd_state_r <= TTEV_BYTE_IDLE;
		end else if (temp_rd) begin
			case (rd_state_r)
				TTEV_BYTE_IDLE: begin
					rd_byte_r  <= word_r[15:8]; // [RL10]
					low_byte_r <= word_r[7:0];
					rd_state_r <= TTEV_BYTE_LOW;
				end
				TTEV_BYTE_LOW: begin
					rd_byte_r  <= low_byte_r; // [RL10]
					rd_state_r <= TTEV_BYTE_IDLE;
				end
				default: begin
					rd_state_r <= TTEV_BYTE_IDLE;
				end
			endcase
		end
	end

	assign temp_rd_byte         = rd_byte_r;
	assign measured_temperature = word_r;

	always_comb begin
		cfg_rdata = cfg_r;
		cfg_rdata[TTEV_CFG_STATUS] = alert_r & cfg_r[TTEV_CFG_OUT_EN];
		cfg_rdata[TTEV_CFG_CLEAR]  = 1'b0;
	end

endmodule : ttev_top

// *** ttev_top_props.sv ***
/* Port checker for the trip and alert logic.
 * Assumes it is bound onto ttev_top and sees only its ports. */
`timescale 1ns/10ps
module ttev_top_props
	import ttev_pkg::*;
#(
	parameter int TEMP_W = 13
) (
	input logic                   ref_clk,
	input logic                   rst,
	input logic                   sample_valid,
	input logic [TTEV_TEMP_W-1:0] ambient_reading,
	input logic [TTEV_TEMP_W-1:0] window_high_limit,
	input logic [TTEV_TEMP_W-1:0] window_low_limit,
	input logic [TTEV_TEMP_W-1:0] critical_limit,
	input logic                   cfg_wr,
	input logic [15:0]            cfg_wdata,
	input logic [15:0]            cfg_rdata,
	input logic                   temp_rd_start,
	input logic                   temp_rd,
	input logic [7:0]             temp_rd_byte,
	input logic [15:0]            measured_temperature,
	input logic                   alert_o,
	input logic                   alert_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic       low_nxt_r;
	logic [7:0] snap_r;
	logic [7:0] exp_r;
	logic       run;
	logic [12:0] t_q;
	assign run = sample_valid && !cfg_rdata[TTEV_CFG_SHUTDOWN];
	// Limits are compared with the resolved reading, so unresolved bits never decide a flag.
	assign t_q = {ambient_reading[12:2], 2'h0};
	// The low byte is the copy taken at the upper-byte read, not the live word.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_nxt_r <= 1'b0;
			snap_r    <= 8'h00;
			exp_r     <= 8'h00;
		end else if (temp_rd_start) begin
			low_nxt_r <= 1'b0;
		end else if (temp_rd) begin
			low_nxt_r <= !low_nxt_r;
			snap_r    <= low_nxt_r ? snap_r : measured_temperature[7:0];
			exp_r     <= low_nxt_r ? snap_r : measured_temperature[15:8];
		end
	end
	pin_data_low_a: assert property (alert_o == 1'b0)
		else $error("alert data not low");
	low_bits_zero_a: assert property (measured_temperature[1:0] == 2'h0)
		else $error("unresolved bits not zero");
	crit_flag_a: assert property (run |=> measured_temperature[15] ==
		($signed($past(t_q)) >= $signed($past(critical_limit))))
		else $error("critical flag wrong");
	above_set_a: assert property (run &&
		$signed(t_q) > $signed(window_high_limit) |=> measured_temperature[14])
		else $error("above flag not set");
	below_clear_a: assert property (run &&
		$signed(t_q) >= $signed(window_low_limit) |=> !measured_temperature[13])
		else $error("below flag not clear");
	temp_field_a: assert property (run |=>
		measured_temperature[12:2] == $past(ambient_reading[12:2]))
		else $error("temperature field wrong");
	pin_released_a: assert property (
		(!cfg_rdata[TTEV_CFG_OUT_EN] && !cfg_rdata[TTEV_CFG_POL]) [*3] |-> alert_oe_n)
		else $error("disabled pin driven");
	shutdown_hold_a: assert property ((cfg_rdata[TTEV_CFG_SHUTDOWN] && !cfg_wr) [*3] |=>
		$stable(alert_oe_n) && $stable(measured_temperature))
		else $error("state moved in shutdown");
	byte_order_a: assert property (temp_rd && !temp_rd_start |=> temp_rd_byte == exp_r)
		else $error("read byte wrong");
	cover property (run ##1 measured_temperature[14]);
	cover property (cfg_rdata[TTEV_CFG_SHUTDOWN] [*3]);
	cover property (temp_rd ##1 temp_rd);
endmodule : ttev_top_props
bind ttev_top ttev_top_props #(.TEMP_W(TEMP_W)) u_props (
	.ref_clk              (ref_clk),
	.rst                  (rst),
	.sample_valid         (sample_valid),
	.ambient_reading      (ambient_reading),
	.window_high_limit    (window_high_limit),
	.window_low_limit     (window_low_limit),
	.critical_limit       (critical_limit),
	.cfg_wr               (cfg_wr),
	.cfg_wdata            (cfg_wdata),
	.cfg_rdata            (cfg_rdata),
	.temp_rd_start        (temp_rd_start),
	.temp_rd              (temp_rd),
	.temp_rd_byte         (temp_rd_byte),
	.measured_temperature (measured_temperature),
	.alert_o              (alert_o),
	.alert_oe_n           (alert_oe_n)
);
